// ===== rtl/ossc_defines.vh
/*
  Constants of the oscillator source and start-up controller: register
  offsets, field positions, reset values, mode codes and timing counts.
  Assumes a 10 MHz core clock and 32-bit APB with byte addresses.
*/
// Notes on behaviour
// - crystal modes wait 1024 input oscillations
// - count starts after reset/power-up timer, wake
// - counting holds execution unless monitor/two-speed
// - monitor or two-speed runs on internal clock
// - 4x multiplier takes external or internal source
// - fuse or soft bit enables; fuse overrides
// - software may select timer oscillator
// - RC/internal modes: output pin gpio or clkout
// - internal mode releases input pin as gpio
// - internal block via mode fuse or select
// - hf source is 16 MHz from 500 kHz
// - hf enabled by hf setting and internal
// - mf enabled by mf setting and internal
// - mf postscaler picks frequency from select field
// - hf ready flag while hf running
// - hf locked flag within 2 percent
// - hf stable flag within half percent
// - mf ready flag while mf running
// - hf/mf trimmed by tuning; lf untrimmed
// - fast start-up settles before hf switch
// - reset loads frequency select with 0111
// - source select decode, cleared on reset
// - tuning is 6-bit signed, reset zero
`ifndef OSSC_DEFINES_VH
`define OSSC_DEFINES_VH

`define OSSC_ADDR_CTRL      12'h000
`define OSSC_ADDR_STAT      12'h004
`define OSSC_ADDR_TRIM      12'h008

`define OSSC_CTRL_SRC_LSB   0
`define OSSC_CTRL_FREQ_LSB  3
`define OSSC_CTRL_PLL_BIT   7

`define OSSC_STAT_HFR_BIT   0
`define OSSC_STAT_HFL_BIT   1
`define OSSC_STAT_HFS_BIT   2
`define OSSC_STAT_MFR_BIT   3
`define OSSC_STAT_OSTS_BIT  4
`define OSSC_STAT_PLL_BIT   5
`define OSSC_STAT_HOLD_BIT  6

`define OSSC_FREQ_RESET     4'h7
`define OSSC_SRC_RESET      2'h0
`define OSSC_TRIM_RESET     6'h00

`define OSSC_MODE_LP        3'h0
`define OSSC_MODE_XT        3'h1
`define OSSC_MODE_HS        3'h2
`define OSSC_MODE_RC        3'h3
`define OSSC_MODE_INTERNAL_OSC_BLOCK    3'h4

`define OSSC_SEL_FUSE       2'h0
`define OSSC_SEL_TIMER      2'h1
`define OSSC_SEL_INTERNAL   2'h2

`define OSSC_STARTUP_COUNT  11'h400

`define OSSC_CLK_NS         100
`define OSSC_FAST_START_NS  1000
`define OSSC_HF_LOCK_NS     2000
`define OSSC_HF_STABLE_NS   5000
`define OSSC_MF_READY_NS    1000

`endif

// ===== rtl/ossc_startup_timer.v
/*
  Crystal start-up timer: counts rising edges of the external oscillator
  input and reports when the full count has been seen.
  Assumes osc_in is asynchronous and well below half the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ossc_defines.vh"

module ossc_startup_timer (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        start,
  input  wire        osc_in,
  output reg         counting,
  output reg         done
);

  reg        sync1_reg;
  reg        sync2_reg;
  reg        last_reg;
  reg [10:0] count_reg;
  wire       edge_seen;

  assign edge_seen = sync2_reg & ~last_reg;

  always @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
      count_reg <= 11'h000;
      counting  <= 1'b0;
      done      <= 1'b0;
    end else if (ce) begin
      sync1_reg <= osc_in;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
      if (start) begin
        count_reg <= 11'h000;
        counting  <= 1'b1;
        done      <= 1'b0;
      end else if (counting && edge_seen) begin
        if (count_reg == `OSSC_STARTUP_COUNT - 11'h001) begin
          counting <= 1'b0;
          done     <= 1'b1;
        end
        count_reg <= count_reg + 11'h001;
      end
    end
  end

endmodule // ossc_startup_timer

`default_nettype wire

// ===== rtl/ossc_top.v
/*
  Oscillator source and start-up controller: APB register file, clock
  source decode, internal oscillator enables and their status flags,
  multiplier enable, pin function and execution hold.
  Assumes fuses are static after reset, por_event, wake_event and
  power_up_timer_done come from logic on clk; osc_input_pin is a pin.
*/
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "ossc_defines.vh"

module ossc_top (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [2:0]  osc_mode_fuse,
  input  wire        pll_fuse_enable,
  input  wire        clock_output_select,
  input  wire        fail_safe_monitor,
  input  wire        two_speed_enable,
  input  wire        power_up_timer_enable,
  input  wire        power_up_timer_done,
  input  wire        por_event,
  input  wire        wake_event,
  input  wire        osc_input_pin,
  output reg         cpu_hold,
  output reg         run_on_internal,
  output reg  [1:0]  sys_clk_source,
  output reg         pll_enable,
  output reg         hf_osc_enable,
  output reg         mf_osc_enable,
  output reg         lf_osc_enable,
  output reg         hf_clk_switch,
  output reg  [3:0]  postscale_shift,
  output reg  [5:0]  hf_mf_trim,
  output reg         osc_in_gpio,
  output reg         osc_out_clkout,
  output reg         osc_out_gpio
);

  // timing counts round up to whole core cycles and fit in a byte
  function [7:0] ns_to_cyc;
    input integer ns;
    integer cyc;
    begin
      cyc       = (ns + `OSSC_CLK_NS - 1) / `OSSC_CLK_NS;
      ns_to_cyc = cyc[7:0];
    end
  endfunction

  localparam [7:0] FAST_CYC   = ns_to_cyc(`OSSC_FAST_START_NS);
  localparam [7:0] LOCK_CYC   = ns_to_cyc(`OSSC_HF_LOCK_NS);
  localparam [7:0] STABLE_CYC = ns_to_cyc(`OSSC_HF_STABLE_NS);
  localparam [7:0] MF_CYC     = ns_to_cyc(`OSSC_MF_READY_NS);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_POWER_UP_TIMER  = 2'h1;
  localparam [1:0] ST_COUNT = 2'h2;

  // frequency codes: 0000/0001 low source, 0010 and 0100..0111 medium,
  // 0011 and 1xxx high
  function is_hf;
    input [3:0] code;
    begin
      is_hf = code[3] | (code == 4'h3);
    end
  endfunction

  function is_mf;
    input [3:0] code;
    begin
      is_mf = (code == 4'h2) | (code[3:2] == 2'h1);
    end
  endfunction

  function is_crystal;
    input [2:0] mode;
    begin
      is_crystal = (mode == `OSSC_MODE_LP) | (mode == `OSSC_MODE_XT) |
                   (mode == `OSSC_MODE_HS);
    end
  endfunction

  function is_internal_osc_block;
    input [2:0] mode;
    begin
      is_internal_osc_block = mode == `OSSC_MODE_INTERNAL_OSC_BLOCK;
    end
  endfunction

  reg  [1:0] src_reg;
  reg  [3:0] freq_reg;
  reg        pll_soft_reg;
  reg  [5:0] trim_reg;
  reg  [1:0] state_reg;
  reg  [7:0] hf_cnt_reg;
  reg  [7:0] mf_cnt_reg;
  reg        hf_ready_reg;
  reg        hf_locked_reg;
  reg        hf_stable_reg;
  reg        mf_ready_reg;
  reg        osts_reg;
  reg        start_pulse;

  wire       st_counting;
  wire       st_done;
  wire       setup_ph;
  wire       access_ph;
  wire       hit_ctrl;
  wire       hit_stat;
  wire       hit_trim;
  wire       mapped;
  wire       internal_osc_block_sel;
  wire       hf_want;
  wire       mf_want;
  wire       xtal_mode;
  wire       bypass_hold;
  wire       pll_req;
  wire [7:0] ctrl_word;
  wire [7:0] stat_word;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable & ce;
  assign hit_ctrl  = paddr == `OSSC_ADDR_CTRL;
  assign hit_stat  = paddr == `OSSC_ADDR_STAT;
  assign hit_trim  = paddr == `OSSC_ADDR_TRIM;
  assign mapped    = hit_ctrl | hit_stat | hit_trim;
  // registered read data lets a zero-wait access phase answer
  assign pready    = access_ph;
  assign pslverr   = access_ph & ~mapped;

  assign internal_osc_block_sel  = is_internal_osc_block(osc_mode_fuse) |
                       src_reg[1];
  assign hf_want     = internal_osc_block_sel & is_hf(freq_reg);
  assign mf_want     = internal_osc_block_sel & is_mf(freq_reg);
  assign xtal_mode   = is_crystal(osc_mode_fuse);
  assign bypass_hold = fail_safe_monitor | two_speed_enable;
  // fuse set means the soft bit has no say at all
  assign pll_req     = pll_fuse_enable | pll_soft_reg;

  assign ctrl_word = {pll_soft_reg, freq_reg, 1'b0, src_reg};
  assign stat_word = {1'b0, cpu_hold, pll_enable, osts_reg,
                      mf_ready_reg, hf_stable_reg, hf_locked_reg,
                      hf_ready_reg};

  ossc_startup_timer u_startup (
    .clk      (clk),
    .rst      (rst),
    .ce       (ce),
    .start    (start_pulse),
    .osc_in   (osc_input_pin),
    .counting (st_counting),
    .done     (st_done)
  );

  // apb register writes and read data capture
  always @(posedge clk) begin
    if (rst) begin
      src_reg      <= `OSSC_SRC_RESET;
      freq_reg     <= `OSSC_FREQ_RESET;
      pll_soft_reg <= 1'b0;
      trim_reg     <= `OSSC_TRIM_RESET;
      prdata       <= 32'h00000000;
    end else if (ce) begin
      if (setup_ph) begin
        if (hit_ctrl) begin
          prdata <= {24'h000000, ctrl_word};
        end else if (hit_stat) begin
          prdata <= {24'h000000, stat_word};
        end else if (hit_trim) begin
          prdata <= {26'h0000000, trim_reg};
        end else begin
          prdata <= 32'h00000000;
        end
      end
      // status has no write path, so it stays read-only
      if (access_ph && pwrite) begin
        if (hit_ctrl) begin
          src_reg      <= pwdata[`OSSC_CTRL_SRC_LSB +: 2];
          freq_reg     <= pwdata[`OSSC_CTRL_FREQ_LSB +: 4];
          pll_soft_reg <= pwdata[`OSSC_CTRL_PLL_BIT];
        end
        if (hit_trim) begin
          trim_reg <= pwdata[5:0];
        end
      end
    end
  end

  // start-up sequencing
  always @(posedge clk) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      start_pulse <= 1'b0;
      osts_reg    <= 1'b0;
    end else if (ce) begin
      start_pulse <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          // outside crystal modes only a por_event with power_up_timer_enable clears the done flag
          if (por_event && power_up_timer_enable) begin
            state_reg <= ST_POWER_UP_TIMER;
            osts_reg  <= 1'b0;
          end else if ((por_event || wake_event) && xtal_mode) begin
            state_reg   <= ST_COUNT;
            start_pulse <= 1'b1;
            osts_reg    <= 1'b0;
          end
        end
        ST_POWER_UP_TIMER: begin
          if (power_up_timer_done && xtal_mode) begin
            state_reg   <= ST_COUNT;
            start_pulse <= 1'b1;
          end else if (power_up_timer_done) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_COUNT: begin
          // a fresh event mid-count drops the edges seen so far
          if (por_event || wake_event) begin
            start_pulse <= 1'b1;
            osts_reg    <= 1'b0;
          // done of the last run still reads high while start is in flight
          end else if (st_done && !start_pulse) begin
            state_reg <= ST_IDLE;
            osts_reg  <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // internal oscillator models: counters from enable to each flag
  always @(posedge clk) begin
    if (rst) begin
      hf_cnt_reg    <= 8'h00;
      mf_cnt_reg    <= 8'h00;
      hf_ready_reg  <= 1'b0;
      hf_locked_reg <= 1'b0;
      hf_stable_reg <= 1'b0;
      mf_ready_reg  <= 1'b0;
    end else if (ce) begin
      if (!hf_want) begin
        hf_cnt_reg    <= 8'h00;
        hf_ready_reg  <= 1'b0;
        hf_locked_reg <= 1'b0;
        hf_stable_reg <= 1'b0;
      end else begin
        if (hf_cnt_reg != STABLE_CYC) begin
          hf_cnt_reg <= hf_cnt_reg + 8'h01;
        end
        // hf is built from mf, so mf must be ready too
        hf_ready_reg  <= mf_ready_reg &
                         (hf_cnt_reg >= FAST_CYC);
        hf_locked_reg <= mf_ready_reg &
                         (hf_cnt_reg >= LOCK_CYC);
        hf_stable_reg <= mf_ready_reg &
                         (hf_cnt_reg >= STABLE_CYC);
      end
      // mf also runs as the reference of the hf multiplier
      if (!(hf_want || mf_want)) begin
        mf_cnt_reg   <= 8'h00;
        mf_ready_reg <= 1'b0;
      end else begin
        if (mf_cnt_reg != MF_CYC) begin
          mf_cnt_reg <= mf_cnt_reg + 8'h01;
        end
        mf_ready_reg <= mf_cnt_reg >= MF_CYC;
      end
    end
  end

  // registered outputs derived from configuration and state
  always @(posedge clk) begin
    if (rst) begin
      cpu_hold        <= 1'b0;
      run_on_internal <= 1'b0;
      sys_clk_source  <= `OSSC_SEL_FUSE;
      pll_enable      <= 1'b0;
      hf_osc_enable   <= 1'b0;
      mf_osc_enable   <= 1'b0;
      lf_osc_enable   <= 1'b0;
      hf_clk_switch   <= 1'b0;
      postscale_shift <= 4'h0;
      hf_mf_trim      <= `OSSC_TRIM_RESET;
      osc_in_gpio     <= 1'b0;
      osc_out_clkout  <= 1'b0;
      osc_out_gpio    <= 1'b0;
    end else if (ce) begin
      cpu_hold        <= st_counting & ~bypass_hold;
      run_on_internal <= st_counting & bypass_hold;
      if (src_reg[1]) begin
        sys_clk_source <= `OSSC_SEL_INTERNAL;
      end else if (src_reg[0]) begin
        sys_clk_source <= `OSSC_SEL_TIMER;
      end else begin
        sys_clk_source <= `OSSC_SEL_FUSE;
      end
      // multiplier is not offered while the internal select is used
      pll_enable    <= pll_req & ~src_reg[1] &
                       (src_reg != `OSSC_SEL_TIMER);
      hf_osc_enable <= hf_want;
      mf_osc_enable <= hf_want | mf_want;
      // lf only when internal is chosen with a low code
      lf_osc_enable <= internal_osc_block_sel & ~hf_want & ~mf_want;
      hf_clk_switch <= hf_ready_reg;
      // divide 16 MHz or 500 kHz down by a power of two
      if (is_hf(freq_reg)) begin
        postscale_shift <= (freq_reg == 4'h3) ?
                           4'h9 : 4'hF - freq_reg;
      end else if (is_mf(freq_reg)) begin
        postscale_shift <= (freq_reg == 4'h2) ?
                           4'h4 : 4'h7 - freq_reg;
      end else begin
        postscale_shift <= 4'h0;
      end
      hf_mf_trim <= trim_reg;
      osc_in_gpio <= is_internal_osc_block(osc_mode_fuse);
      if (osc_mode_fuse == `OSSC_MODE_RC ||
          is_internal_osc_block(osc_mode_fuse)) begin
        osc_out_clkout <= clock_output_select;
        osc_out_gpio   <= ~clock_output_select;
      end else begin
        osc_out_clkout <= 1'b0;
        osc_out_gpio   <= 1'b0;
      end
    end
  end

endmodule // ossc_top

`default_nettype wire

// ===== test/ossc_properties.sv
/*
  Concurrent checks on the ports of ossc_top.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module ossc_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       wake_event,
  input wire logic [2:0] osc_mode_fuse,
  input wire logic       pll_fuse_enable,
  input wire logic       clock_output_select,
  input wire logic       fail_safe_monitor,
  input wire logic       two_speed_enable,
  input wire logic       cpu_hold,
  input wire logic       run_on_internal,
  input wire logic [1:0] sys_clk_source,
  input wire logic       pll_enable,
  input wire logic       hf_osc_enable,
  input wire logic       hf_clk_switch,
  input wire logic       osc_in_gpio,
  input wire logic       osc_out_clkout
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [13:0] hold_cnt;
  // saturates so a stuck hold cannot wrap into a false pass
  always_ff @(posedge clk) begin
    if (rst || !(cpu_hold || run_on_internal)) hold_cnt <= 14'h0000;
    else if (hold_cnt != 14'h3FFF) hold_cnt <= hold_cnt + 14'h0001;
  end
  chk_full_count: assert property (
    $fell(cpu_hold) |-> hold_cnt >= 14'h0400) else $error("hold ended early");
  chk_wake_hold: assert property (
    wake_event && ce && osc_mode_fuse <= 3'h2 && !fail_safe_monitor && !two_speed_enable
    |-> ##3 cpu_hold) else $error("wake did not hold execution");
  chk_hold_monitor: assert property (
    cpu_hold |-> !fail_safe_monitor && !two_speed_enable) else $error("hold with monitor");
  chk_run_internal: assert property (
    run_on_internal |-> fail_safe_monitor || two_speed_enable) else $error("bad internal run");
  chk_pll_fuse_wins: assert property (
    (pll_fuse_enable && sys_clk_source == 2'h0)[*4] |-> $past(pll_enable))
    else $error("fuse did not enable multiplier");
  chk_pll_gated_off: assert property (
    (sys_clk_source != 2'h0)[*3] |-> !pll_enable) else $error("multiplier on off fuse source");
  chk_clkout_mode: assert property (
    osc_out_clkout |-> $past(clock_output_select)
      && ($past(osc_mode_fuse) == 3'h3 || $past(osc_mode_fuse) == 3'h4))
    else $error("clock output in wrong mode");
  chk_input_gpio: assert property (
    (osc_mode_fuse == 3'h4 && ce)[*2] |-> osc_in_gpio) else $error("input pin not released");
  chk_gpio_only_int: assert property (
    osc_in_gpio |-> $past(osc_mode_fuse) == 3'h4) else $error("input pin released wrongly");
  chk_hf_source: assert property (
    hf_osc_enable && $past(hf_osc_enable) |-> $past(osc_mode_fuse) == 3'h4
      || sys_clk_source[1] || $past(sys_clk_source[1])) else $error("hf on without internal");
  chk_switch_after_hf: assert property (
    $rose(hf_clk_switch) |-> $past(hf_osc_enable, 8)) else $error("switch before settling");
  cover property ($fell(cpu_hold));
  cover property ($rose(run_on_internal));
  cover property ($rose(hf_clk_switch));
endmodule // ossc_properties
bind ossc_top ossc_properties u_props (.clk, .rst, .ce, .wake_event, .osc_mode_fuse,
  .pll_fuse_enable, .clock_output_select, .fail_safe_monitor, .two_speed_enable, .cpu_hold,
  .run_on_internal, .sys_clk_source, .pll_enable, .hf_osc_enable, .hf_clk_switch,
  .osc_in_gpio, .osc_out_clkout);
`default_nettype wire

// ===== test/ossc_xtal_model.sv
/*
  Behavioural crystal on the oscillator input pin.
  Assumes run is high only in crystal modes; the pin rests low otherwise.
*/
`timescale 1ns/1ns
`default_nettype none
module ossc_xtal_model #(parameter int HALF_NS = 325) (
  input  wire logic run,
  output var  logic osc
);
  // small offset keeps every pin change off the core clock edges
  initial begin
    osc = 1'b0;
    #10;
    // a stopped crystal sits at its rest level, no stale toggling
    forever begin
      #HALF_NS;
      osc = run ? ~osc : 1'b0;
    end
  end
endmodule // ossc_xtal_model
`default_nettype wire

// ===== test/testbench.sv
/*
  Self-checking bench for ossc_top: APB register access, source decode,
  internal oscillator flags, start-up hold and pin functions.
  Assumes the crystal model runs whenever a crystal mode is fused.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ossc_defines.vh"
module testbench;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, osc, pfuse = 1'b0, cksel = 1'b0, fsm = 1'b0;
  logic        pute = 1'b0, putd = 1'b0, por = 1'b0, wake = 1'b0, tse = 1'b0, ce = 1'b1;
  logic [2:0]  mode = `OSSC_MODE_XT;
  logic        hold, rint, plle, hfe, mfe, lfe, sw, igp, ock, ogp;
  logic [1:0]  src;
  logic [3:0]  pss;
  logic [5:0]  trim;
  integer      fails = 0, samples_checked = 0, n;
  always #50 clk = ~clk;
  ossc_xtal_model XTAL (.run(mode <= 3'h2), .osc(osc));
  ossc_top DUT (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .osc_mode_fuse(mode), .pll_fuse_enable(pfuse),
    .clock_output_select(cksel), .fail_safe_monitor(fsm), .two_speed_enable(tse),
    .power_up_timer_enable(pute), .power_up_timer_done(putd), .por_event(por),
    .wake_event(wake), .osc_input_pin(osc), .cpu_hold(hold), .run_on_internal(rint),
    .sys_clk_source(src), .pll_enable(plle), .hf_osc_enable(hfe), .mf_osc_enable(mfe),
    .lf_osc_enable(lfe), .hf_clk_switch(sw), .postscale_shift(pss), .hf_mf_trim(trim),
    .osc_in_gpio(igp), .osc_out_clkout(ock), .osc_out_gpio(ogp));
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task bail(input logic c);
    if (c) begin
      fails = fails + 1;
      give_verdict;
    end
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // idle cycle after each transfer keeps psel from being driven twice at one edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      @(posedge clk);
      while (pready !== 1'b1 && k < 16) begin
        k = k + 1;
        @(posedge clk);
      end
      bail(k >= 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task settle;
    repeat (3) @(posedge clk);
  endtask
  task wait_free(output integer c);
    begin
      c = 0;
      while ((hold | rint) !== 1'b0 && c < 20000) begin
        c = c + 1;
        @(posedge clk);
      end
      bail(c >= 20000);
    end
  endtask
  task pulse_wake;
    begin
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      settle;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    xfer(1'b0, `OSSC_ADDR_CTRL, 32'h0); check(rd, 32'h38);
    xfer(1'b0, `OSSC_ADDR_TRIM, 32'h0); check(rd, 32'h0);
    xfer(1'b0, 12'h00C, 32'h0); check({rd[0], err}, 2'b01);
    xfer(1'b1, `OSSC_ADDR_TRIM, 32'h3F);
    xfer(1'b0, `OSSC_ADDR_TRIM, 32'h0); check(rd, 32'h3F);
    check(trim, 6'h3F);
    xfer(1'b1, `OSSC_ADDR_CTRL, 32'h7A);
    n = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && n < 100) begin
      xfer(1'b0, `OSSC_ADDR_STAT, 32'h0);
      n = n + 1;
    end
    bail(n >= 100);
    check({hfe, mfe, pss}, {2'b11, 4'h0});
    repeat (60) @(posedge clk);
    check(sw, 1'b1);
    xfer(1'b1, `OSSC_ADDR_STAT, 32'h0);
    xfer(1'b0, `OSSC_ADDR_STAT, 32'h0); check(rd[3:0], 4'hF);
    xfer(1'b1, `OSSC_ADDR_CTRL, 32'h32); settle; check({hfe, mfe, pss}, {2'b01, 4'h1});
    xfer(1'b1, `OSSC_ADDR_CTRL, 32'h02); settle; check({hfe, mfe, lfe}, 3'b001);
    xfer(1'b1, `OSSC_ADDR_CTRL, 32'h38); settle;
    xfer(1'b0, `OSSC_ADDR_STAT, 32'h0); check(rd[3:0], 4'h0);
    xfer(1'b1, `OSSC_ADDR_CTRL, 32'hB8); settle; check(plle, 1'b1);
    xfer(1'b1, `OSSC_ADDR_CTRL, 32'h38); pfuse <= 1'b1; settle; check(plle, 1'b1);
    pfuse <= 1'b0; settle; check(plle, 1'b0);
    for (n = 0; n < 3; n = n + 1) begin
      xfer(1'b1, `OSSC_ADDR_CTRL, 32'h38 | n); settle;
      check(src, n[1:0]);
    end
    pulse_wake; check(hold, 1'b1);
    xfer(1'b0, `OSSC_ADDR_STAT, 32'h0); check(rd[6:4], 3'h4);
    repeat (300) @(posedge clk);
    pulse_wake; wait_free(n);
    // 1024 crystal edges at 650 ns from the restart, not from the first wake
    check(n >= 6580 && n <= 6700, 1'b1);
    xfer(1'b0, `OSSC_ADDR_STAT, 32'h0); check(rd[6:4], 3'h1);
    pute <= 1'b1; por <= 1'b1; @(posedge clk); por <= 1'b0;
    repeat (10) @(posedge clk); check(hold, 1'b0);
    putd <= 1'b1; settle; @(posedge clk); check(hold, 1'b1);
    wait_free(n);
    pute <= 1'b0; putd <= 1'b0; fsm <= 1'b1; settle;
    pulse_wake; check({hold, rint}, 2'b01);
    wait_free(n);
    fsm <= 1'b0; tse <= 1'b1; mode <= `OSSC_MODE_LP; settle;
    pulse_wake; check({hold, rint}, 2'b01);
    wait_free(n); check(n >= 6580 && n <= 6700, 1'b1);
    tse <= 1'b0; xfer(1'b1, `OSSC_ADDR_CTRL, 32'h38);
    mode <= `OSSC_MODE_INTERNAL_OSC_BLOCK; cksel <= 1'b1; settle;
    check({igp, ock, ogp, hfe, mfe}, 5'b11001);
    mode <= `OSSC_MODE_RC; cksel <= 1'b0; settle; check({igp, ock, ogp}, 3'b001);
    mode <= `OSSC_MODE_HS; settle; check({igp, ock, ogp}, 3'b000);
    ce <= 1'b0; mode <= `OSSC_MODE_INTERNAL_OSC_BLOCK; settle; check(igp, 1'b0);
    ce <= 1'b1; settle; check(igp, 1'b1);
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
